// ### hdl/if_pll_divider_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "if_pll_params.svh"

// What this block does
// RULE1: A word ending in 0111 is the feedback counter word, and the host ends such words so.
// RULE2: The feedback word carries swallow count above main count with fixed top bits.
// RULE3: Programmed words act only while use-default-settings is 0, else defaults apply.
// RULE4: The feedback divider is a 9-bit main counter with a 4-bit swallow counter, pulse-swallow.
// RULE5: The host programs swallow count from 0 to 15.
// RULE6: The host programs main count from 1 to 511.
// RULE7: Feedback division is sixteen times main plus swallow, swallow kept below main.
// RULE8: A word ending in 01111 is the reference divider word.
// RULE9: The host places the 9-bit reference divide just above the suffix, fixed top bits.
// RULE10: The host programs the reference divide from 2 to 511.
// RULE11: A word ending in 011111 is the factory test word.
// RULE12: The host avoids the test word, or sends a top one with zeros below.
// RULE13: Suffixes 10 and 011 select other words, so decoding is prefix-free.
// RULE14: Words shift in MSB first on serial clock rise and latch on latch enable rise.
// RULE15: A word with no matching suffix changes no register.
module if_pll_divider_config (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial configuration pins
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_enable_line,
  // Control word zero default select, from outside the domain
  input wire logic use_default_settings,
  // Divider input ticks
  input wire logic vco_tick,
  input wire logic ref_tick,
  // Applied settings
  output logic [8:0] main_count,
  output logic [3:0] swallow_count,
  output logic [8:0] ref_divide,
  output logic [17:0] test_data,
  // Events
  output logic word_taken,
  output logic fb_div_pulse,
  output logic ref_div_pulse
);

  serial_word_if wrd ();

  logic dflt_a_reg;
  logic dflt_b_reg;
  logic [`MAIN_W-1:0] main_word_reg;
  logic [`SWAL_W-1:0] swal_word_reg;
  logic [`REF_W-1:0] ref_word_reg;
  logic [`TEST_W-1:0] test_word_reg;
  logic word_taken_reg;
  logic [`MAIN_W-1:0] main_count_reg;
  logic [`SWAL_W-1:0] swallow_count_reg;
  logic [`REF_W-1:0] ref_divide_reg;
  logic [`TEST_W-1:0] test_data_reg;
  logic [4:0] presc_cnt_reg;
  logic [`MAIN_W-1:0] main_left_reg;
  logic [`SWAL_W-1:0] swal_left_reg;
  logic [`REF_W-1:0] ref_cnt_reg;
  logic fb_div_pulse_reg;
  logic ref_div_pulse_reg;
  logic [4:0] presc_last;
  logic presc_out;
  logic main_wrap;
  logic ref_out;
  if_pll_pkg::word_kind_e kind;

  // ============================================================
  // Suffix decoder, longest code first
  function automatic if_pll_pkg::word_kind_e decode_kind(input logic [`WORD_W-1:0] w);
    if (w[5:0] == `SFX_TEST) begin
      decode_kind = if_pll_pkg::WK_TEST; // RULE11
    end else if (w[4:0] == `SFX_REF) begin
      decode_kind = if_pll_pkg::WK_REFERENCE; // RULE8
    end else if (w[3:0] == `SFX_FB) begin
      decode_kind = if_pll_pkg::WK_FEEDBACK; // RULE1
    end else if (w[2:0] == `SFX_LBW || w[1:0] == `SFX_CP) begin
      decode_kind = if_pll_pkg::WK_OTHER; // RULE13
    end else begin
      decode_kind = if_pll_pkg::WK_NONE;
    end
  endfunction : decode_kind

  // ============================================================
  // Serial receiver
  serial_word_rx u_rx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .latch_enable_line(latch_enable_line),
    .wrd(wrd)
  );

  assign kind = decode_kind(wrd.word);

  // Default select pin synchroniser
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dflt_a_reg <= 1'b1;
      dflt_b_reg <= 1'b1;
    end else begin
      dflt_a_reg <= use_default_settings;
      dflt_b_reg <= dflt_a_reg;
    end
  end

  // ============================================================
  // Word registers; unmatched suffixes fall through untouched
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_word_reg <= `DEF_MAIN;
      swal_word_reg <= `DEF_SWAL;
      ref_word_reg <= `DEF_REF;
      test_word_reg <= `DEF_TEST;
    end else if (wrd.strobe) begin
      unique case (kind)
        if_pll_pkg::WK_FEEDBACK: begin
          main_word_reg <= wrd.word[`FB_MAIN_MSB:`FB_MAIN_LSB]; // RULE2
          swal_word_reg <= wrd.word[`FB_SWAL_MSB:`FB_SWAL_LSB]; // RULE2
        end
        if_pll_pkg::WK_REFERENCE: begin
          ref_word_reg <= wrd.word[`REF_MSB:`REF_LSB];
        end
        if_pll_pkg::WK_TEST: begin
          test_word_reg <= wrd.word[`TEST_MSB:`TEST_LSB];
        end
        if_pll_pkg::WK_OTHER, if_pll_pkg::WK_NONE: begin
        end // RULE15
      endcase
    end
  end

  // Pulse for any word this block owns
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_taken_reg <= 1'b0;
    end else begin
      word_taken_reg <= wrd.strobe && (kind == if_pll_pkg::WK_FEEDBACK ||
        kind == if_pll_pkg::WK_REFERENCE || kind == if_pll_pkg::WK_TEST);
    end
  end

  // ============================================================
  // Applied settings: defaults while the select is high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_count_reg <= `DEF_MAIN;
      swallow_count_reg <= `DEF_SWAL;
      ref_divide_reg <= `DEF_REF;
      test_data_reg <= `DEF_TEST;
    end else if (dflt_b_reg) begin
      main_count_reg <= `DEF_MAIN; // RULE3
      swallow_count_reg <= `DEF_SWAL;
      ref_divide_reg <= `DEF_REF;
      test_data_reg <= `DEF_TEST;
    end else begin
      main_count_reg <= main_word_reg; // RULE3
      swallow_count_reg <= swal_word_reg;
      ref_divide_reg <= ref_word_reg;
      test_data_reg <= test_word_reg;
    end
  end

  // ============================================================
  // Dual-modulus prescaler: 17 while swallows remain, else 16
  assign presc_last = (swal_left_reg != 4'h0) ? `PRESC_HIGH_LAST : `PRESC_LOW_LAST; // RULE4
  assign presc_out = vco_tick && (presc_cnt_reg >= presc_last);
  assign main_wrap = presc_out && (main_left_reg <= 9'h001);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt_reg <= 5'h00;
    end else if (vco_tick) begin
      presc_cnt_reg <= presc_out ? 5'h00 : presc_cnt_reg + 5'h01;
    end
  end

  // Main and swallow counters, reloaded at each output pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_left_reg <= `DEF_MAIN;
      swal_left_reg <= `DEF_SWAL;
    end else if (main_wrap) begin
      main_left_reg <= main_count_reg; // RULE7
      swal_left_reg <= swallow_count_reg;
    end else if (presc_out) begin
      main_left_reg <= main_left_reg - 9'h001;
      if (swal_left_reg != 4'h0) begin
        swal_left_reg <= swal_left_reg - 4'h1;
      end
    end
  end

  // ============================================================
  // Reference divider
  assign ref_out = ref_tick && (ref_cnt_reg >= ref_divide_reg - 9'h001);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_reg <= 9'h000;
    end else if (ref_tick) begin
      ref_cnt_reg <= ref_out ? 9'h000 : ref_cnt_reg + 9'h001;
    end
  end

  // Output pulses
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fb_div_pulse_reg <= 1'b0;
      ref_div_pulse_reg <= 1'b0;
    end else begin
      fb_div_pulse_reg <= main_wrap;
      ref_div_pulse_reg <= ref_out;
    end
  end

  assign main_count = main_count_reg;
  assign swallow_count = swallow_count_reg;
  assign ref_divide = ref_divide_reg;
  assign test_data = test_data_reg;
  assign word_taken = word_taken_reg;
  assign fb_div_pulse = fb_div_pulse_reg;
  assign ref_div_pulse = ref_div_pulse_reg;

  // ============================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Any word ending in the feedback suffix, whatever its main count parity
  sequence s_fb_word;
    wrd.strobe && wrd.word[3:0] == `SFX_FB;
  endsequence

  sequence s_fb_taken;
    ##1 main_word_reg == $past(wrd.word[`FB_MAIN_MSB:`FB_MAIN_LSB])
      && swal_word_reg == $past(wrd.word[`FB_SWAL_MSB:`FB_SWAL_LSB]);
  endsequence

  property p_fb_word;
    s_fb_word |-> s_fb_taken;
  endproperty
  a_fb_word: assert property (p_fb_word) else $error("feedback word not stored"); // RULE1

  property p_ref_word;
    wrd.strobe && wrd.word[4:0] == `SFX_REF |=>
      ref_word_reg == $past(wrd.word[`REF_MSB:`REF_LSB]) && $stable(main_word_reg);
  endproperty
  a_ref_word: assert property (p_ref_word) else $error("reference word not stored"); // RULE8

  property p_test_word;
    wrd.strobe && wrd.word[5:0] == `SFX_TEST |=>
      test_word_reg == $past(wrd.word[`TEST_MSB:`TEST_LSB])
      && $stable(ref_word_reg);
  endproperty
  a_test_word: assert property (p_test_word) else $error("test word not stored"); // RULE11

  property p_other_word;
    wrd.strobe && (wrd.word[1:0] == `SFX_CP || wrd.word[2:0] == `SFX_LBW) |=>
      $stable(main_word_reg) && $stable(ref_word_reg) && $stable(test_word_reg) && !word_taken;
  endproperty
  a_other_word: assert property (p_other_word) else $error("short suffix hit a word"); // RULE13

  property p_unmapped;
    wrd.strobe && kind == if_pll_pkg::WK_NONE |=> $stable(swal_word_reg) &&
      $stable(main_word_reg) && $stable(ref_word_reg) && $stable(test_word_reg);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped word changed state"); // RULE15

  property p_default_hold;
    dflt_b_reg [*2] |-> main_count == `DEF_MAIN && ref_divide == `DEF_REF;
  endproperty
  a_default_hold: assert property (p_default_hold) else $error("default not applied"); // RULE3

  property p_program_apply;
    !dflt_b_reg |=> main_count == $past(main_word_reg) && swallow_count == $past(swal_word_reg);
  endproperty
  a_program_apply: assert property (p_program_apply) else $error("program not applied"); // RULE3

  property p_swallow_mod;
    presc_out && swal_left_reg != 4'h0 |-> presc_cnt_reg == `PRESC_HIGH_LAST;
  endproperty
  a_swallow_mod: assert property (p_swallow_mod) else $error("swallow cycle not 17"); // RULE4

  property p_fb_reload;
    main_wrap |=> fb_div_pulse && main_left_reg == $past(main_count)
      && swal_left_reg == $past(swallow_count);
  endproperty
  a_fb_reload: assert property (p_fb_reload) else $error("feedback reload wrong"); // RULE7

  property p_ref_wrap;
    ref_tick && ref_divide >= 9'h002 && ref_cnt_reg == ref_divide - 9'h001 |=>
      ref_div_pulse && ref_cnt_reg == 9'h000;
  endproperty
  a_ref_wrap: assert property (p_ref_wrap) else $error("reference wrap wrong"); // RULE10

endmodule : if_pll_divider_config

`default_nettype wire

// ### hdl/if_pll_params.svh
`ifndef IF_PLL_PARAMS_SVH
`define IF_PLL_PARAMS_SVH

// ============================================================
// Serial word layout
`define WORD_W 24
`define MAIN_W 9
`define SWAL_W 4
`define REF_W 9
`define TEST_W 18
`define FB_MAIN_LSB 4
`define FB_MAIN_MSB 12
`define FB_SWAL_LSB 13
`define FB_SWAL_MSB 16
`define REF_LSB 5
`define REF_MSB 13
`define TEST_LSB 6
`define TEST_MSB 23

// ============================================================
// Address suffixes, shortest first
`define SFX_CP 2'h2
`define SFX_LBW 3'h3
`define SFX_FB 4'h7
`define SFX_REF 5'h0F
`define SFX_TEST 6'h1F

// ============================================================
// Built-in default settings and reset values
`define DEF_MAIN 9'h010
`define DEF_SWAL 4'h0
`define DEF_REF 9'h002
`define DEF_TEST 18'h20000

// ============================================================
// Dual-modulus prescaler terminal counts (divide by 16 or 17)
`define PRESC_LOW_LAST 5'h0F
`define PRESC_HIGH_LAST 5'h10

`endif

// ### hdl/if_pll_pkg.sv
// ============================================================
// Types shared by the configuration block
package if_pll_pkg;

  // Which configuration word a suffix selects
  typedef enum logic [2:0] {
    WK_FEEDBACK,
    WK_REFERENCE,
    WK_TEST,
    WK_OTHER,
    WK_NONE
  } word_kind_e;

endpackage : if_pll_pkg

// ### hdl/serial_word_if.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Completed serial word from receiver to register bank
interface serial_word_if;
  logic [23:0] word;
  logic strobe;
  modport rx (output word, output strobe);
  modport core (input word, input strobe);
endinterface : serial_word_if

`default_nettype wire

// ### hdl/serial_word_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "if_pll_params.svh"

// ============================================================
// Three-wire serial receiver, sampled on the system clock
module serial_word_rx (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial pins
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_enable_line,
  // Completed word
  serial_word_if.rx wrd
);

  logic [2:0] sync_a_reg;
  logic [2:0] sync_b_reg;
  logic clk_prev_reg;
  logic le_prev_reg;
  logic [`WORD_W-1:0] shift_reg;
  logic [`WORD_W-1:0] word_reg;
  logic strobe_reg;
  logic clk_rise;
  logic le_rise;

  // ============================================================
  // Two-stage synchronisers: clock, data, latch enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_a_reg <= 3'h0;
      sync_b_reg <= 3'h0;
    end else begin
      sync_a_reg <= {latch_enable_line, ser_data, ser_clk};
      sync_b_reg <= sync_a_reg;
    end
  end

  // Edge history
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_reg <= 1'b0;
      le_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= sync_b_reg[0];
      le_prev_reg <= sync_b_reg[2];
    end
  end

  assign clk_rise = sync_b_reg[0] & ~clk_prev_reg;
  assign le_rise = sync_b_reg[2] & ~le_prev_reg;

  // Shift in MSB first on serial clock rise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 24'h000000;
    end else if (clk_rise) begin
      shift_reg <= {shift_reg[`WORD_W-2:0], sync_b_reg[1]}; // RULE14
    end
  end

  // Hand over the word on latch enable rise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= 24'h000000;
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= le_rise; // RULE14
      if (le_rise) begin
        word_reg <= shift_reg;
      end
    end
  end

  assign wrd.word = word_reg;
  assign wrd.strobe = strobe_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_latch_word;
    le_rise |=> strobe_reg && word_reg == $past(shift_reg) ##1 !strobe_reg;
  endproperty
  a_latch_word: assert property (p_latch_word) else $error("latch rise lost word"); // RULE14

  property p_shift_msb_first;
    clk_rise |=> shift_reg[0] == $past(sync_b_reg[1]) && shift_reg[1] == $past(shift_reg[0]);
  endproperty
  a_shift_msb_first: assert property (p_shift_msb_first) else $error("bad shift order"); // RULE14

endmodule : serial_word_rx

`default_nettype wire

// ### dv/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Host controller driving the three-wire configuration link
module serial_host_model (
  // Serial pins toward the device
  output logic ser_clk,
  output logic ser_data,
  output logic latch_enable_line
);
  localparam time HALF = 24ns;

  // Link idles with clock low and latch low
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_enable_line = 1'b0;
  end

  // Feedback word: fixed top bits, swallow above main, suffix 0111
  function automatic logic [23:0] fb_word(input logic [8:0] m, input logic [3:0] s);
    return {7'h08, s, m, 4'h7};
  endfunction : fb_word

  // Reference word: fixed top bits, divide above suffix 01111
  function automatic logic [23:0] ref_word(input logic [8:0] r);
    return {10'h0C2, r, 5'h0F};
  endfunction : ref_word

  // Test word in its only sanctioned form
  function automatic logic [23:0] test_word();
    return {18'h20000, 6'h1F};
  endfunction : test_word

  // MSB first, data set while clock low, latch after last bit
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data = w[i];
      #HALF;
      ser_clk = 1'b1;
      #HALF;
      ser_clk = 1'b0;
    end
    ser_data = ~w[0]; // Released line shows no stale level
    #HALF;
    latch_enable_line = 1'b1;
    #HALF;
    latch_enable_line = 1'b0;
    #HALF;
  endtask : send_word
endmodule : serial_host_model

`default_nettype wire

// ### dv/test_if_pll_divider_config.sv
`timescale 1ns/1ps
`default_nettype none

module test_if_pll_divider_config;
  // ============================================================
  // Signals
  logic clk_sys, rst_n, use_default_settings, vco_tick, ref_tick;
  wire ser_clk, ser_data, latch_enable_line;
  logic [8:0] main_count, ref_divide, m, r;
  logic [3:0] swallow_count, s;
  logic [17:0] test_data, t;
  logic word_taken, fb_div_pulse, ref_div_pulse;
  logic [5:0] bad_sfx [5] = '{6'h2A, 6'h2B, 6'h05, 6'h24, 6'h3F};
  int n_mismatch, num_checks, n_taken;

  // ============================================================
  // Instances
  if_pll_divider_config if_pll_divider_config_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .latch_enable_line(latch_enable_line), .use_default_settings(use_default_settings),
    .vco_tick(vco_tick), .ref_tick(ref_tick), .main_count(main_count),
    .swallow_count(swallow_count), .ref_divide(ref_divide), .test_data(test_data),
    .word_taken(word_taken), .fb_div_pulse(fb_div_pulse), .ref_div_pulse(ref_div_pulse)
  );
  serial_host_model serial_host_model_inst (
    .ser_clk(ser_clk), .ser_data(ser_data), .latch_enable_line(latch_enable_line)
  );

  // Clock generator
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Random divider input ticks
  always @(posedge clk_sys) begin
    vco_tick <= 1'($urandom % 2);
    ref_tick <= 1'($urandom % 2);
  end

  // Count stored-word pulses
  always @(posedge clk_sys) begin
    if (word_taken === 1'b1) n_taken++;
  end

  // ============================================================
  // Tasks
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  // Send one word and count the stored pulses
  task automatic put(input logic [23:0] w, input logic exp_taken);
    n_taken = 0;
    serial_host_model_inst.send_word(w);
    repeat (8) @(posedge clk_sys);
    check(24'(n_taken), 24'(exp_taken));
  endtask : put

  task automatic expect_cfg(input logic [8:0] em, input logic [3:0] es,
                            input logic [8:0] er, input logic [17:0] et);
    check(24'(main_count), 24'(em));
    check(24'(swallow_count), 24'(es));
    check(24'(ref_divide), 24'(er));
    check(24'(test_data), 24'(et));
  endtask : expect_cfg

  // Legal random field values
  task automatic draw(input int top);
    m = 9'(1 + $urandom % top);
    s = 4'($urandom % ((m > 15) ? 16 : m));
    r = 9'(2 + $urandom % (top - 1));
  endtask : draw

  task automatic load();
    put(serial_host_model_inst.fb_word(m, s), 1'b1);
    put(serial_host_model_inst.ref_word(r), 1'b1);
  endtask : load

  // Ticks per output pulse, skipping periods still on old values
  task automatic div_period(input logic sel, input logic [12:0] exp);
    int n;
    int cnt;
    n = 0;
    cnt = 0;
    while (n < 3) begin
      @(posedge clk_sys);
      if ((sel ? fb_div_pulse : ref_div_pulse) === 1'b1) begin
        if (n == 2) check(24'(cnt), 24'(exp));
        n++;
        cnt = 0;
      end
      cnt += int'(sel ? vco_tick : ref_tick);
    end
  endtask : div_period

  // ============================================================
  // Watchdog
  initial begin
    #400us;
    n_mismatch++;
    final_report();
  end

  // ============================================================
  // Main sequence
  initial begin
    void'($urandom(32'hA74021C2));
    rst_n = 1'b0;
    use_default_settings = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    n_taken = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    expect_cfg(9'h010, 4'h0, 9'h002, 18'h20000);
    // Words stored while defaults held, applied once released
    draw(511);
    load();
    expect_cfg(9'h010, 4'h0, 9'h002, 18'h20000);
    use_default_settings <= 1'b0;
    repeat (6) @(posedge clk_sys);
    expect_cfg(m, s, r, 18'h20000);
    // Boundary then random field values
    for (int i = 0; i < 6; i++) begin
      draw(511);
      if (i == 0) {m, s, r} = {9'h1FF, 4'hF, 9'h1FF};
      if (i == 1) {m, s, r} = {9'h001, 4'h0, 9'h002};
      load();
      expect_cfg(m, s, r, 18'h20000);
    end
    // Test word with odd data, then its proper form
    t = 18'($urandom);
    put({t, 6'h1F}, 1'b1);
    expect_cfg(m, s, r, t);
    put(serial_host_model_inst.test_word(), 1'b1);
    expect_cfg(m, s, r, 18'h20000);
    // Other and unmatched suffixes leave everything alone
    for (int i = 0; i < 5; i++) begin
      put({18'($urandom), bad_sfx[i]}, 1'b0);
      expect_cfg(m, s, r, 18'h20000);
    end
    // Divider periods, smallest legal setting first
    for (int i = 0; i < 4; i++) begin
      draw(20);
      if (i == 0) {m, s, r} = {9'h001, 4'h0, 9'h002};
      load();
      div_period(1'b1, 13'({m, 4'h0}) + 13'(s));
      div_period(1'b0, 13'(r));
    end
    // Defaults back on
    use_default_settings <= 1'b1;
    repeat (6) @(posedge clk_sys);
    expect_cfg(9'h010, 4'h0, 9'h002, 18'h20000);
    final_report();
  end
endmodule : test_if_pll_divider_config

`default_nettype wire
